/* core/wdr_pkg.sv */
// Purpose: Shared constants and carriers for the watchdog refresh block
// Assumes: 24-bit down-counter, one system clock
// Notes: Roll-over value lives here; counter width is also written out as [23:0] in the other files
package wdr_pkg;
	localparam int CNT_W = 24;
	localparam logic [23:0] CNT_ZERO = 24'h000000;
	localparam logic [23:0] CNT_MAX = 24'hffffff;
	localparam logic [23:0] CNT_RST = 24'hffffff;

	// Time-out response option
	localparam logic RESP_INT = 1'b1;
	localparam logic RESP_RESET = 1'b0;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01
	} wdr_state_type;

	// Status flags seen by software
	typedef struct packed {
		logic timeoutFlag;
		logic stopFlag;
	} wdr_status_type;

	// Event outputs of one time-out
	typedef struct packed {
		logic irqPulse;
		logic resetReq;
		logic stopRecover;
	} wdr_event_type;
endpackage : wdr_pkg

/* core/wdr_flags.sv */
// Purpose: Sticky time-out and stop flags
// Assumes: Set and clear from same clock domain
// Notes: A set in the clear cycle wins
`timescale 1ns/1ps
module wdr_flags (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// Events
	input wire logic setTimeout,
	input wire logic setStop,
	input wire logic statusRead,
	// Flags
	output wdr_pkg::wdr_status_type status
);
	wdr_pkg::wdr_status_type status_reg;
	wdr_pkg::wdr_status_type status_next;

	always_comb begin
		status_next = status_reg;
		if (statusRead) begin
			status_next.timeoutFlag = 1'b0;
			status_next.stopFlag = 1'b0;
		end
		if (setTimeout) begin
			status_next.timeoutFlag = 1'b1;
		end
		if (setStop) begin
			status_next.stopFlag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_reg <= '0;
		end else if (clkEn) begin
			status_reg <= status_next;
		end
	end

	assign status = status_reg;

	a_flag_sticky: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && status_reg.timeoutFlag && !statusRead
		|=> status_reg.timeoutFlag)
		else $error("timeout flag dropped without read");

	a_set_wins: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && setTimeout && statusRead |=> status_reg.timeoutFlag)
		else $error("timeout set lost against read");
endmodule : wdr_flags

/* core/wdr_watchdog.sv */
// Purpose: Watchdog down-counter with refresh and time-out response
// Assumes: Control inputs come from logic on sys_clk
// Notes: Reset response leaves flags alone; reset logic acts on resetReq
// How it works
// - First enable loads counter from reload value.
// - Counter decrements toward zero unless refreshed.
// - Refresh reloads counter, then counting resumes from reload.
// - Debugger mode refreshes every cycle so no time-out occurs.
// - Zero means time-out; option bit picks interrupt or reset.
// - Interrupt mode time-out raises request and sets time-out flag.
// - After interrupt time-out counter wraps to all ones, keeps going.
// - Reset status read clears time-out flag.
// - Interrupt mode in stop mode starts stop recovery plus request.
// - Interrupt mode time-out in stop mode sets both time-out and stop flags; reset mode sets neither.
`timescale 1ns/1ps
module wdr_watchdog (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// Control
	input wire logic enable,
	input wire logic refresh,
	input wire logic debugMode,
	input wire logic stopMode,
	input wire logic timeoutResponseOption,
	input wire logic [23:0] reloadValue,
	input wire logic statusRead,
	// Status and events
	output logic [23:0] count,
	output logic running,
	output wdr_pkg::wdr_status_type status,
	output wdr_pkg::wdr_event_type events
);
	wdr_pkg::wdr_state_type state_reg;
	logic [23:0] count_reg;
	wdr_pkg::wdr_event_type events_reg;
	logic timeout;
	logic intMode;

	////////////////////////////////////////////////////////////////////
	// Time-out detection; debugger refresh masks it
	assign intMode = (timeoutResponseOption == wdr_pkg::RESP_INT);
	assign timeout = (state_reg == wdr_pkg::ST_RUN) && enable
		&& !refresh && !debugMode
		&& (count_reg == wdr_pkg::CNT_ZERO);

	////////////////////////////////////////////////////////////////////
	// Enable state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= wdr_pkg::ST_OFF;
		end else if (clkEn) begin
			unique case (state_reg)
				wdr_pkg::ST_OFF: begin
					if (enable) begin
						state_reg <= wdr_pkg::ST_RUN;
					end
				end
				wdr_pkg::ST_RUN: begin
					if (!enable) begin
						state_reg <= wdr_pkg::ST_OFF;
					end
				end
				default: begin
					state_reg <= wdr_pkg::ST_OFF;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Down-counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// After system reset the next enable reloads
			count_reg <= wdr_pkg::CNT_RST;
		end else if (clkEn) begin
			if (state_reg == wdr_pkg::ST_OFF) begin
				if (enable) begin
					count_reg <= reloadValue;
				end
			end else if (enable) begin
				if (refresh || debugMode) begin
					count_reg <= reloadValue;
				end else if (count_reg == wdr_pkg::CNT_ZERO) begin
					// Wrap instead of reload; software must refresh
					count_reg <= wdr_pkg::CNT_MAX;
				end else begin
					count_reg <= count_reg - 24'h000001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Time-out events, one cycle each
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			events_reg <= '0;
		end else if (clkEn) begin
			events_reg.irqPulse <= timeout && intMode;
			events_reg.stopRecover <= timeout && intMode
				&& stopMode;
			events_reg.resetReq <= timeout && !intMode;
		end else begin
			// Frozen clock must not stretch a pulse
			events_reg <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky flags
	wdr_flags u_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.clkEn(clkEn),
		.setTimeout(timeout && intMode),
		.setStop(timeout && intMode && stopMode),
		.statusRead(statusRead),
		.status(status)
	);

	assign count = count_reg;
	assign running = (state_reg == wdr_pkg::ST_RUN);
	assign events = events_reg;

	////////////////////////////////////////////////////////////////////
	// Checks: loading and counting
	a_first_load: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && state_reg == wdr_pkg::ST_OFF && enable
		|=> count_reg == $past(reloadValue))
		else $error("first enable did not load reload value");
	a_run_entry: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && !running && enable
		|=> running)
		else $error("enable did not start the counter");
	a_off_hold: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && !running && !enable
		|=> !running && count_reg == $past(count_reg))
		else $error("idle counter moved");
	a_count_down: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && running && enable && !refresh && !debugMode
		&& count_reg != wdr_pkg::CNT_ZERO
		|=> count_reg == $past(count_reg) - 24'h000001)
		else $error("counter did not decrement");
	a_disabled_hold: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && running && !enable
		|=> !running && count_reg == $past(count_reg))
		else $error("disabled counter moved");
	a_frozen_count: assert property (
		@(posedge sys_clk) disable iff (rst)
		!clkEn
		|=> count_reg == $past(count_reg) && state_reg == $past(state_reg))
		else $error("frozen clock changed counter state");
	a_refresh_load: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && running && enable && refresh
		|=> count_reg == $past(reloadValue))
		else $error("refresh did not reload");
	a_debug_quiet: assert property (
		@(posedge sys_clk) disable iff (rst)
		debugMode
		|-> !timeout)
		else $error("time-out under debugger");
	a_debug_load: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && running && enable && debugMode
		|=> count_reg == $past(reloadValue))
		else $error("debugger mode did not reload");

	////////////////////////////////////////////////////////////////////
	// Checks: time-out and its response
	a_zero_timeout: assert property (
		@(posedge sys_clk) disable iff (rst)
		running && enable && !refresh && !debugMode
		&& count_reg == wdr_pkg::CNT_ZERO
		|-> timeout)
		else $error("zero count gave no time-out");
	a_timeout_zero: assert property (
		@(posedge sys_clk) disable iff (rst)
		timeout
		|-> count_reg == wdr_pkg::CNT_ZERO)
		else $error("time-out away from zero");
	a_timeout_run: assert property (
		@(posedge sys_clk) disable iff (rst)
		timeout
		|-> running && enable)
		else $error("time-out while stopped");
	a_one_response: assert property (
		@(posedge sys_clk) disable iff (rst)
		!(events_reg.irqPulse && events_reg.resetReq))
		else $error("both responses at once");
	a_int_pulse: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && intMode
		|=> events_reg.irqPulse && !events_reg.resetReq
		##1 !events_reg.irqPulse)
		else $error("interrupt not a single pulse");
	a_irq_cause: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.irqPulse
		|-> $past(timeout) && $past(intMode))
		else $error("interrupt without time-out");
	a_flag_set: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && intMode
		|=> status.timeoutFlag)
		else $error("time-out flag not set");
	a_wrap_max: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout
		|=> count_reg == wdr_pkg::CNT_MAX)
		else $error("counter did not wrap to maximum");
	a_wrap_run: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout
		|=> running)
		else $error("counter stopped after time-out");
	a_max_count: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && running && enable && !refresh && !debugMode
		&& count_reg == wdr_pkg::CNT_MAX
		|=> count_reg == wdr_pkg::CNT_MAX - 24'h000001)
		else $error("counter did not go on from maximum");
	a_stop_recover: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && intMode && stopMode
		|=> events_reg.stopRecover && events_reg.irqPulse)
		else $error("stop time-out gave no recovery");
	a_stop_cause: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.stopRecover
		|-> events_reg.irqPulse)
		else $error("recovery without interrupt");
	a_no_stop: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && !stopMode
		|=> !events_reg.stopRecover)
		else $error("recovery outside stop mode");
	a_stop_both: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && intMode && stopMode
		|=> events_reg.stopRecover && status.stopFlag
		&& status.timeoutFlag)
		else $error("stop time-out flags or recovery missing");
	a_reset_req: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && !intMode
		|=> events_reg.resetReq && !events_reg.irqPulse)
		else $error("reset mode time-out gave no reset request");
	a_reset_cause: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.resetReq
		|-> $past(timeout) && !$past(intMode))
		else $error("reset request without time-out");
	a_reset_noflag: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && timeout && !intMode && !status.timeoutFlag
		|=> !status.timeoutFlag)
		else $error("reset mode set the time-out flag");
	a_reset_pulse: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.resetReq
		|=> !events_reg.resetReq)
		else $error("reset request longer than one cycle");
	a_reset_clear: assert property (
		@(posedge sys_clk)
		rst
		|=> !running && count_reg == wdr_pkg::CNT_RST && events_reg == '0)
		else $error("reset left counter or events set");

	////////////////////////////////////////////////////////////////////
	// Checks: flags and pulse widths
	a_read_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && statusRead && !timeout
		|=> !status.timeoutFlag)
		else $error("status read did not clear flag");
	a_stop_clear: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && statusRead && !(timeout && intMode && stopMode)
		|=> !status.stopFlag)
		else $error("status read did not clear stop flag");
	a_irq_gap: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.irqPulse
		|=> !events_reg.irqPulse)
		else $error("interrupt longer than one cycle");
	a_stop_pulse: assert property (
		@(posedge sys_clk) disable iff (rst)
		events_reg.stopRecover
		|=> !events_reg.stopRecover)
		else $error("recovery longer than one cycle");
	a_stopflag_sticky: assert property (
		@(posedge sys_clk) disable iff (rst)
		clkEn && status.stopFlag && !statusRead
		|=> status.stopFlag)
		else $error("stop flag dropped without read");
	a_frozen_events: assert property (
		@(posedge sys_clk) disable iff (rst)
		!clkEn
		|=> events_reg == '0)
		else $error("event stretched by frozen clock");
	a_flags_reset: assert property (
		@(posedge sys_clk)
		rst
		|=> status == '0)
		else $error("reset left a flag set");
endmodule : wdr_watchdog

/* tb/wdr_cpu_model.sv */
// Purpose: CPU and interrupt controller stand-in for the watchdog
// Assumes: Output changes at the falling edge like the bench
// Notes: Reads reset status once per request, then drops it
`timescale 1ns/1ps
module wdr_cpu_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Service
	input wire logic svcEn,
	input wire logic irqPulse,
	output logic statusRead
);
	logic pendReg = 1'b0;
	initial statusRead = 1'b0;
	always @(negedge sys_clk) begin
		// Status read first, so the request is cleared after it
		statusRead <= svcEn && pendReg && !statusRead;
		if (rst || statusRead)
			pendReg <= 1'b0;
		else if (irqPulse)
			pendReg <= 1'b1;
	end
endmodule : wdr_cpu_model

/* tb/test_wdr_watchdog.sv */
// Purpose: Self-checking bench for the watchdog block
// Assumes: clkEn tied high; CPU model services requests
// Notes: Small reload values keep time-outs short
`timescale 1ns/1ps
module test_wdr_watchdog;
	logic sys_clk, rst, enable, refresh, debugMode, stopMode, opt;
	logic svcEn, statusRead, running;
	logic [23:0] reloadValue, count;
	wdr_pkg::wdr_status_type status;
	wdr_pkg::wdr_event_type events;
	int err_count = 0;
	int tests_run = 0;
	int n;
	wdr_watchdog wdr_watchdog_inst (.sys_clk(sys_clk), .rst(rst),
		.clkEn(1'b1), .enable(enable), .refresh(refresh),
		.debugMode(debugMode), .stopMode(stopMode),
		.timeoutResponseOption(opt), .reloadValue(reloadValue),
		.statusRead(statusRead), .count(count), .running(running),
		.status(status), .events(events));
	wdr_cpu_model wdr_cpu_model_inst (.sys_clk(sys_clk), .rst(rst),
		.svcEn(svcEn), .irqPulse(events.irqPulse),
		.statusRead(statusRead));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick
	// Off for a cycle first, so the enable counts as a first enable
	task automatic start(input logic [23:0] r);
		enable = 1'b0;
		tick(1);
		reloadValue = r;
		enable = 1'b1;
		tick(1);
	endtask : start
	task automatic wait_evt(output int k);
		for (k = 1; k < 100; k++) begin
			tick(1);
			if (events !== 3'h0)
				return;
		end
		err_count++;
		give_verdict;
	endtask : wait_evt
	////////////////////////////////////////////////////////////////
	task automatic t_load_refresh;
		start(24'h000010);
		chk(count, 24'h000010);
		chk(running, 1'b1);
		tick(3);
		chk(count, 24'h00000d);
		refresh = 1'b1;
		tick(1);
		refresh = 1'b0;
		chk(count, 24'h000010);
		tick(1);
		chk(count, 24'h00000f);
		$display("load and refresh done");
	endtask : t_load_refresh
	task automatic t_debug;
		start(24'h000002);
		debugMode = 1'b1;
		tick(10);
		chk(count, 24'h000002);
		chk(events, 3'h0);
		debugMode = 1'b0;
		$display("debug done");
	endtask : t_debug
	task automatic t_int;
		opt = wdr_pkg::RESP_INT;
		start(24'h000003);
		wait_evt(n);
		chk(n, 4);
		chk({events, status}, 5'h12);
		chk(count, 24'hffffff);
		tick(1);
		chk({events, status}, 5'h02);
		tick(1);
		chk(status, 2'h0);
		chk(count, 24'hfffffd);
		$display("interrupt time-out done");
	endtask : t_int
	task automatic t_stop;
		stopMode = 1'b1;
		start(24'h000001);
		wait_evt(n);
		chk(events, 3'h5);
		chk(status, 2'h3);
		tick(2);
		chk(status, 2'h0);
		stopMode = 1'b0;
		$display("stop time-out done");
	endtask : t_stop
	task automatic t_reset;
		opt = wdr_pkg::RESP_RESET;
		start(24'h000002);
		wait_evt(n);
		chk(events, 3'h2);
		chk(status, 2'h0);
		start(24'h000005);
		chk(count, 24'h000005);
		$display("reset time-out done");
	endtask : t_reset
	// Reset in mid-run with enable held: restart must reload
	task automatic t_midreset;
		opt = wdr_pkg::RESP_INT;
		start(24'h000008);
		tick(2);
		rst = 1'b1;
		tick(2);
		chk(count, wdr_pkg::CNT_RST);
		chk({running, status, events}, 6'h00);
		rst = 1'b0;
		tick(1);
		chk(count, 24'h000008);
		tick(1);
		chk(count, 24'h000007);
		$display("mid-run reset done");
	endtask : t_midreset
	////////////////////////////////////////////////////////////////
	initial begin
		{rst, enable, refresh, debugMode, stopMode, opt, svcEn} = 7'h41;
		reloadValue = 24'h000000;
		tick(20);
		rst = 1'b0;
		chk(count, wdr_pkg::CNT_RST);
		t_load_refresh;
		t_debug;
		t_int;
		t_stop;
		t_reset;
		t_midreset;
		give_verdict;
	end
endmodule : test_wdr_watchdog
